// file: core/lpcsq_pkg.sv
// Shared constants and types for the low power card detect sequencer.
package lpcsq_pkg;

	// Cycles spent in each reduced start-up stage before the RF pulse
	localparam int unsigned STARTUP_A_CYC = 4;
	localparam int unsigned STARTUP_B_CYC = 4;

	// Confirmation filter: samples per pulse and periods needed to wake
	localparam int unsigned FILTER_SAMPLES = 16;
	localparam int unsigned FILTER_PERIODS = 3;

	// Detection options layout (location kept for reference only)
	localparam logic [7:0] DETECT_OPTIONS_OFS = 8'h3a;
	localparam int unsigned OPT_BOOST_BIT = 3;
	localparam int unsigned OPT_FILTER_BIT = 2;
	localparam logic [3:0] DETECT_OPTIONS_RST = 4'h0;

	// Value of the wake request after reset
	localparam logic IRQ_RST = 1'b0;

	// Sequencer phases
	typedef enum logic [2:0] {
		LPCSQ_IDLE,
		LPCSQ_STANDBY,
		LPCSQ_START_A,
		LPCSQ_START_B,
		LPCSQ_PULSE
	} lpcsq_state_t;

endpackage

// file: core/lpcsq_seq.sv
// Top of the autonomous low power card detect sequencer.
// Rules of the card detect mode
// RULE1: Host calibrates idle antenna before entering mode.
// RULE2: Entering mode starts timed standby first.
// RULE3: Standby expiry runs two-stage start-up, no RF.
// RULE4: Timed RF pulse follows; detuning sampled during it.
// RULE5: No card sensed: back to standby, timer restarted.
// RULE6: Detuning detected: wake fully and raise interrupt.
// RULE7: Loop ends only on detection or reset.
// RULE8: Host interface disabled while mode is active.
// RULE9: Software option enables boost during RF pulse.
// RULE10: Woken host runs normal polling to activate.
// RULE11: Filter: 16 samples, three hit periods wake.
// RULE12: Boost option bit 3, filter bit 2.
// RULE13: Timer reloads latched at entry, reused each loop.
`timescale 1ns/1ps
`default_nettype none

module lpcsq_seq
	import lpcsq_pkg::*;
#(
	parameter int unsigned TIMER_W = 16
) (
	input wire logic core_clk, // 40 MHz core clock
	input wire logic rstn, // Async reset, active low
	input wire logic enter_mode, // Host command pulse: start detection
	input wire logic cal_done, // Idle antenna calibration is complete
	input wire logic [TIMER_W-1:0] standby_reload, // Standby length, cycles
	input wire logic [TIMER_W-1:0] pulse_reload, // RF pulse length, cycles
	input wire logic [3:0] detect_options, // Option bits, boost and filter
	input wire logic detune_sense, // Antenna departs calibrated state
	input wire logic irq_ack, // Host clears the wake interrupt
	output logic card_detect_mode_q, // Detection loop active
	output logic host_if_en_q, // Host interface usable
	output logic startup_a_q, // First reduced start-up stage
	output logic startup_b_q, // Second reduced start-up stage
	output logic rf_on_q, // RF field on
	output logic boost_on_q, // Transmit boost pump running
	output logic irq_q // Wake interrupt to host
);

	// Pulse timer must hold the minimum filter pulse length
	if (TIMER_W < 5 || TIMER_W > 32) begin : g_bad_width
		$error("lpcsq_seq: TIMER_W must be within 5..32");
	end

	localparam logic [TIMER_W-1:0] MIN_FILT_PULSE = TIMER_W'(FILTER_SAMPLES);
	localparam logic [4:0] SAMP_END = 5'(FILTER_SAMPLES);
	localparam logic [1:0] LAST_PERIOD = 2'(FILTER_PERIODS - 1);
	localparam logic [2:0] SU_A_LAST = 3'(STARTUP_A_CYC - 1);
	localparam logic [2:0] SU_B_LAST = 3'(STARTUP_B_CYC - 1);

	lpcsq_state_t st_q; // Current phase
	lpcsq_state_t st_d; // Next phase
	logic [TIMER_W-1:0] standby_len_q; // Latched standby reload
	logic [TIMER_W-1:0] pulse_len_q; // Latched pulse reload
	logic boost_q; // Latched tx_boost_enable
	logic filt_q; // Latched wake_confirm_filter
	logic [2:0] su_cnt_q; // Cycles spent in a start-up stage
	logic [4:0] pcyc_q; // Cycles into the current pulse period
	logic hit_q; // Some filter sample sensed detuning
	logic [1:0] periods_q; // Consecutive periods that sensed detuning
	logic enter_ok; // Entry command accepted
	logic stby_load; // Restart the standby timer
	logic pulse_load; // Start a pulse period
	logic [TIMER_W-1:0] stby_val; // Standby timer load value
	logic [TIMER_W-1:0] pulse_val; // Pulse timer load value
	logic stby_done; // Standby interval elapsed
	logic pulse_done; // Pulse period elapsed
	logic su_last; // Last cycle of a start-up stage
	logic samp_now; // Filter sample slot this cycle
	logic period_hit; // Current period sensed detuning
	logic wake; // Detection confirmed this cycle

	// Entry is refused until calibration is reported done [RULE1]
	assign enter_ok = (st_q == LPCSQ_IDLE) && enter_mode && cal_done;
	// First standby uses the value offered at entry [RULE13]
	assign stby_val = enter_ok ? standby_reload : standby_len_q;
	// Filter stretches a short pulse so all samples fit in it [RULE11]
	assign pulse_val = (filt_q && (pulse_len_q < MIN_FILT_PULSE)) ?
		MIN_FILT_PULSE : pulse_len_q;
	assign su_last = (st_q == LPCSQ_START_A) ? (su_cnt_q == SU_A_LAST) :
		(su_cnt_q == SU_B_LAST);
	// Filter samples the first slots of each pulse period [RULE11]
	assign samp_now = filt_q && (st_q == LPCSQ_PULSE) && (pcyc_q < SAMP_END);
	// Without filter a single sample at pulse end decides [RULE4]
	assign period_hit = filt_q ? (hit_q || (samp_now && detune_sense)) :
		detune_sense;

	// Standby interval timer
	lpcsq_timer #(
		.WIDTH(TIMER_W)
	) u_standby_timer (
		.core_clk(core_clk),
		.rstn(rstn),
		.load(stby_load),
		.value(stby_val),
		.done(stby_done),
		.busy()
	);

	// RF pulse interval timer
	lpcsq_timer #(
		.WIDTH(TIMER_W)
	) u_pulse_timer (
		.core_clk(core_clk),
		.rstn(rstn),
		.load(pulse_load),
		.value(pulse_val),
		.done(pulse_done),
		.busy()
	);

	// Next phase and timer loads
	always_comb begin
		st_d = st_q;
		stby_load = 1'b0;
		pulse_load = 1'b0;
		wake = 1'b0;
		unique case (st_q)
			LPCSQ_IDLE: begin
				// Idle accepts only the entry command [RULE2]
				if (enter_ok) begin
					st_d = LPCSQ_STANDBY;
					stby_load = 1'b1;
				end
			end
			LPCSQ_STANDBY: begin
				// Standby expiry opens the start-up [RULE3]
				if (stby_done) begin
					st_d = LPCSQ_START_A;
				end
			end
			LPCSQ_START_A: begin
				if (su_last) begin
					st_d = LPCSQ_START_B; // [RULE3]
				end
			end
			LPCSQ_START_B: begin
				// RF only after both stages [RULE3] [RULE4]
				if (su_last) begin
					st_d = LPCSQ_PULSE;
					pulse_load = 1'b1;
				end
			end
			LPCSQ_PULSE: begin
				if (pulse_done) begin
					if (period_hit) begin
						if (!filt_q || periods_q == LAST_PERIOD) begin
							// Confirmed detuning ends the loop [RULE6] [RULE11]
							wake = 1'b1;
							st_d = LPCSQ_IDLE;
						end else begin
							// Another confirmation period, RF stays on [RULE11]
							pulse_load = 1'b1;
						end
					end else begin
						// Miss goes back to standby [RULE5] [RULE11]
						st_d = LPCSQ_STANDBY;
						stby_load = 1'b1;
					end
				end
			end
		endcase
	end

	// Phase register; nothing but a wake or reset leaves the loop [RULE7]
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= LPCSQ_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Settings are captured at entry since the host is locked out later
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			standby_len_q <= '0;
			pulse_len_q <= '0;
			boost_q <= DETECT_OPTIONS_RST[OPT_BOOST_BIT];
			filt_q <= DETECT_OPTIONS_RST[OPT_FILTER_BIT];
		end else if (enter_ok) begin
			standby_len_q <= standby_reload; // [RULE13]
			pulse_len_q <= pulse_reload; // [RULE13]
			boost_q <= detect_options[OPT_BOOST_BIT]; // [RULE9] [RULE12]
			filt_q <= detect_options[OPT_FILTER_BIT]; // [RULE12]
		end
	end

	// Start-up stage cycle counter, cleared on each phase change
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			su_cnt_q <= '0;
		end else if (st_d != st_q) begin
			su_cnt_q <= '0;
		end else begin
			su_cnt_q <= su_cnt_q + 3'h1;
		end
	end

	// Pulse sample slots and hit memory per period [RULE11]
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pcyc_q <= '0;
			hit_q <= 1'b0;
		end else if (pulse_load) begin
			pcyc_q <= '0;
			hit_q <= 1'b0;
		end else begin
			if (st_q == LPCSQ_PULSE && pcyc_q < SAMP_END) begin
				pcyc_q <= pcyc_q + 5'h1;
			end
			if (samp_now && detune_sense) begin
				hit_q <= 1'b1;
			end
		end
	end

	// Consecutive hit periods; any miss or new loop starts over [RULE11]
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			periods_q <= '0;
		end else if (stby_load) begin
			periods_q <= '0;
		end else if (pulse_done && period_hit && !wake) begin
			periods_q <= periods_q + 2'h1;
		end
	end

	// Phase outputs registered from the next phase
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			card_detect_mode_q <= 1'b0;
			host_if_en_q <= 1'b1;
			startup_a_q <= 1'b0;
			startup_b_q <= 1'b0;
			rf_on_q <= 1'b0;
			boost_on_q <= 1'b0;
		end else begin
			card_detect_mode_q <= (st_d != LPCSQ_IDLE);
			host_if_en_q <= (st_d == LPCSQ_IDLE); // [RULE8]
			startup_a_q <= (st_d == LPCSQ_START_A);
			startup_b_q <= (st_d == LPCSQ_START_B);
			rf_on_q <= (st_d == LPCSQ_PULSE); // [RULE4]
			boost_on_q <= (st_d == LPCSQ_PULSE) && boost_q; // [RULE9]
		end
	end

	// Wake interrupt; a new wake beats a same-cycle acknowledge [RULE6]
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= IRQ_RST;
		end else if (wake) begin
			irq_q <= 1'b1;
		end else if (irq_ack) begin
			irq_q <= 1'b0;
		end
	end

	// Checks on the sequencing
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_startup;
		startup_a_q [*4] ##1 startup_b_q [*4];
	endsequence
	sequence s_pulse_start;
		rf_on_q && !startup_b_q;
	endsequence

	a_entry_standby: assert property ( // [RULE2]
		enter_ok |=> card_detect_mode_q && !rf_on_q && !startup_a_q)
		else $error("entry did not go to standby");
	a_startup_order: assert property ( // [RULE3]
		$rose(startup_a_q) |-> s_startup ##1 s_pulse_start)
		else $error("start-up stages out of order");
	a_standby_dark: assert property ( // [RULE3]
		(st_q == LPCSQ_STANDBY) && !stby_done |=> !rf_on_q)
		else $error("RF on during standby");
	// A one-cycle standby may end right after the miss, so look at once
	a_miss_return: assert property ( // [RULE5]
		(st_q == LPCSQ_PULSE) && pulse_done && !period_hit
		|=> !rf_on_q && card_detect_mode_q && !startup_a_q)
		else $error("missed pulse did not return to standby");
	a_wake_irq: assert property ( // [RULE6]
		wake |=> irq_q && !card_detect_mode_q && host_if_en_q)
		else $error("wake did not raise interrupt");
	a_loop_holds: assert property ( // [RULE7]
		(st_q != LPCSQ_IDLE) && !wake |=> card_detect_mode_q)
		else $error("loop stopped without detection");
	a_host_locked: assert property ( // [RULE8]
		card_detect_mode_q |-> !host_if_en_q)
		else $error("host interface enabled in detect mode");
	a_boost_gate: assert property ( // [RULE9]
		boost_on_q |-> rf_on_q && boost_q)
		else $error("boost outside a boosted pulse");
	// A minimum-length pulse ends on its last sample slot
	a_filter_three: assert property ( // [RULE11]
		wake && filt_q |-> periods_q == LAST_PERIOD &&
		pcyc_q >= SAMP_END - 5'h1)
		else $error("filtered wake before three full periods");
	a_irq_sticky: assert property ( // [RULE6]
		irq_q && !irq_ack && !wake |=> irq_q)
		else $error("interrupt dropped without acknowledge");

endmodule

`default_nettype wire

// file: core/lpcsq_timer.sv
// Reloadable down-counting interval timer used for standby and pulse.
`timescale 1ns/1ps
`default_nettype none

module lpcsq_timer #(
	parameter int unsigned WIDTH = 16
) (
	input wire logic core_clk, // Core clock
	input wire logic rstn, // Async reset, active low
	input wire logic load, // Start a new interval
	input wire logic [WIDTH-1:0] value, // Interval length in cycles
	output logic done, // High in the last cycle of the interval
	output logic busy // Interval running
);

	logic [WIDTH-1:0] cnt_q; // Cycles left including this one
	logic run_q; // Interval in progress

	// A zero value behaves as one, so an interval never hangs
	assign done = run_q && (cnt_q <= WIDTH'(1));
	assign busy = run_q;

	// Count down; a load in the expiring cycle restarts at once
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load) begin
			cnt_q <= value;
			run_q <= 1'b1;
		end else if (done) begin
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q - WIDTH'(1);
		end
	end

endmodule

`default_nettype wire

// file: tb/lpcsq_host_model.sv
// Host processor model facing the card detect sequencer.
`timescale 1ns/1ps
`default_nettype none

module lpcsq_host_model #(
	parameter int CAL_CYC = 6
) (
	input wire logic core_clk, // Core clock
	input wire logic rstn, // Reset, active low
	input wire logic start, // Bench asks for detection mode
	input wire logic early, // Bench lets entry skip calibration
	input wire logic irq_q, // Wake interrupt from the device
	input wire logic host_if_en_q, // Device interface usable
	output logic enter_mode, // Entry command
	output logic cal_done, // Idle antenna calibration complete
	output logic irq_ack, // Interrupt clear
	output int polls // Polling runs after a wake
);
	int cal_cnt; // Calibration progress

	// Calibrate once after every reset
	always @(negedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cal_cnt <= 0;
			cal_done <= 1'b0;
		end else if (cal_cnt < CAL_CYC) begin
			cal_cnt <= cal_cnt + 1;
		end else begin
			cal_done <= 1'b1;
		end
	end

	// Entry waits for calibration unless a test wants a refusal
	assign enter_mode = start & (cal_done | early);

	// Interface is touched only once the device hands it back
	always @(negedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_ack <= 1'b0;
			polls <= 0;
		end else begin
			irq_ack <= irq_q & host_if_en_q & !irq_ack;
			if (irq_q & host_if_en_q & !irq_ack) begin
				polls <= polls + 1;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/lpcsq_seq_tb.sv
// Self-checking bench for the card detect sequencer.
`timescale 1ns/1ps
`default_nettype none

module lpcsq_seq_tb;
	import lpcsq_pkg::*;

	typedef struct {int s; int p; logic [3:0] opt;} lpcsq_row_t;

	logic core_clk, rstn, start, early, detune_sense; // Bench drives
	logic enter_mode, cal_done, irq_ack; // Host model drives
	logic [15:0] standby_reload, pulse_reload; // Interval lengths
	logic [3:0] detect_options; // Boost and filter bits
	logic card_detect_mode_q, host_if_en_q, startup_a_q, startup_b_q;
	logic rf_on_q, boost_on_q, irq_q; // Device outputs
	int polls, cyc, num_errors, n_checks, t, f;
	// Plain loops; the last row shows bits 1:0 are ignored
	lpcsq_row_t rows [4] = '{'{3, 5, 4'h8}, '{7, 1, 4'h0},
		'{0, 0, 4'h8}, '{2, 3, 4'h3}};

	lpcsq_seq DUT (.core_clk(core_clk), .rstn(rstn),
		.enter_mode(enter_mode), .cal_done(cal_done),
		.standby_reload(standby_reload), .pulse_reload(pulse_reload),
		.detect_options(detect_options), .detune_sense(detune_sense),
		.irq_ack(irq_ack), .card_detect_mode_q(card_detect_mode_q),
		.host_if_en_q(host_if_en_q), .startup_a_q(startup_a_q),
		.startup_b_q(startup_b_q), .rf_on_q(rf_on_q),
		.boost_on_q(boost_on_q), .irq_q(irq_q));

	lpcsq_host_model host (.core_clk(core_clk), .rstn(rstn),
		.start(start), .early(early), .irq_q(irq_q),
		.host_if_en_q(host_if_en_q), .enter_mode(enter_mode),
		.cal_done(cal_done), .irq_ack(irq_ack), .polls(polls));

	// 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Cycle index, stable when read at the falling edge
	always @(posedge core_clk) cyc <= cyc + 1;

	function automatic logic sel(input int w);
		case (w)
			0: return rf_on_q;
			1: return irq_q;
			2: return startup_a_q;
			default: return startup_b_q;
		endcase
	endfunction

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bounded wait for an output level; returns the cycle index
	task automatic wt(input int w, input logic v, output int tt);
		int n;
		n = 0;
		while (sel(w) !== v && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 400) begin
			num_errors++;
			summarize();
		end
		tt = cyc;
	endtask

	// Enter, one missed pulse, then a hit and the wake
	task automatic run_row(input lpcsq_row_t r);
		int e, s, p;
		s = (r.s == 0) ? 1 : r.s;
		p = (r.p == 0) ? 1 : r.p;
		standby_reload = 16'(r.s);
		pulse_reload = 16'(r.p);
		detect_options = r.opt;
		detune_sense = 1'b0;
		start = 1'b1;
		e = cyc;
		@(negedge core_clk);
		start = 1'b0;
		chk(host_if_en_q, 0);
		wt(2, 1, t);
		chk(t - e, s + 1);
		wt(3, 1, t);
		chk(t - e, s + 5);
		wt(0, 1, t);
		chk(t - e, s + 9);
		chk(boost_on_q, r.opt[3]);
		wt(0, 0, f);
		chk(f - t, p);
		wt(2, 1, t);
		chk(t - f, s);
		detune_sense = 1'b1;
		wt(0, 1, f);
		wt(1, 1, t);
		chk(t - f, p);
		chk(host_if_en_q, 1);
		wt(1, 0, t);
		detune_sense = 1'b0;
		$display("row test done");
	endtask

	initial begin
		{rstn, start, early, detune_sense} = 4'h0;
		{standby_reload, pulse_reload, detect_options} = 36'h0;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(negedge core_clk);
		chk({card_detect_mode_q, host_if_en_q, rf_on_q, irq_q}, 4'h4);
		rstn = 1'b1;
		repeat (8) @(negedge core_clk);
		foreach (rows[i]) run_row(rows[i]);
		$display("row tests done");
		// Filter: two hit periods then a miss, then three hits
		{standby_reload, pulse_reload, detect_options} = {16'h2, 16'h4, 4'h4};
		detune_sense = 1'b1;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		wt(0, 1, t);
		repeat (31) @(negedge core_clk);
		detune_sense = 1'b0;
		wt(0, 0, f);
		chk(f - t, 48);
		chk(card_detect_mode_q, 1);
		detune_sense = 1'b1;
		wt(0, 1, t);
		wt(1, 1, f);
		chk(f - t, 48);
		wt(1, 0, t);
		detune_sense = 1'b0;
		chk(polls, 5);
		$display("filter test done");
		// Loop keeps running until reset
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		// Three full pulses, each followed by a return to standby
		repeat (3) begin
			wt(0, 1, t);
			wt(0, 0, f);
		end
		chk({card_detect_mode_q, host_if_en_q}, 2'h2);
		rstn = 1'b0;
		@(negedge core_clk);
		chk({card_detect_mode_q, host_if_en_q, rf_on_q}, 3'h2);
		// Entry before calibration is refused
		rstn = 1'b1;
		early = 1'b1;
		start = 1'b1;
		@(negedge core_clk);
		{start, early} = 2'h0;
		repeat (3) @(negedge core_clk);
		chk(card_detect_mode_q, 0);
		$display("reset and refusal tests done");
		summarize();
	end
endmodule
`default_nettype wire
